// ===== design/trc_pkg.sv
// Constants for the result and calibration register bank of one converter channel.
// Assumes a single 50 MHz clock and a serial register port decoded outside this file.
package trc_pkg;
  localparam int          REG_W           = 24;
  localparam int          VAL_W           = 23;
  localparam int          PAR_BIT         = 23;
  localparam logic [7:0]  STOP6_OFS       = 8'h1A;
  localparam logic [7:0]  CAL1_OFS        = 8'h1B;
  localparam logic [7:0]  CAL2_OFS        = 8'h1C;
  localparam logic [23:0] RESULT_RST      = 24'h000000;
  localparam int          MIN_INTERVAL_NS = 12;
  localparam int          CLK_PERIOD_NS   = 20;
  // Least time rounds up, never below one cycle.
  localparam int          MIN_INTERVAL_CYC = (MIN_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          MAX_AVG         = 128;
  localparam int          AVG_SH_W        = 3;
endpackage : trc_pkg

// ===== design/trc_result_regs.sv
// Result bank: accumulates averaged results and serves reads on the register port.
// Assumes the measurement core delivers results as one-cycle strobes on ref_clk_in.
`timescale 1ns/10ps
`default_nettype none
module trc_result_regs (
  // Clock and reset.
  input  wire logic                         ref_clk_in,
  input  wire logic                         sys_rst_in,
  // Measurement core results.
  input  wire logic                         result_vld_in,
  input  wire logic [trc_pkg::VAL_W-1:0]    stop6_interval_value_in,
  input  wire logic [trc_pkg::VAL_W-1:0]    cal_value_first_in,
  input  wire logic [trc_pkg::VAL_W-1:0]    cal_value_second_in,
  input  wire logic [trc_pkg::AVG_SH_W-1:0] avg_log2_in,
  // Register port.
  input  wire logic                         channel_chip_select_in,
  input  wire logic                         rd_en_in,
  input  wire logic                         wr_en_in,
  input  wire logic [7:0]                   addr_in,
  output logic      [trc_pkg::REG_W-1:0]    rd_data_out,
  output logic                              rd_valid_out
);
  import trc_pkg::*;

  localparam int ACC_W = VAL_W + 7;

  logic [ACC_W-1:0] acc_r   [3];
  logic [ACC_W-1:0] acc_nxt [3];
  logic [REG_W-1:0] res_r   [3];
  logic [REG_W-1:0] res_nxt [3];
  logic [7:0]       cnt_r, cnt_nxt;
  logic [7:0]       target;
  logic [VAL_W-1:0] sample  [3];
  logic [REG_W-1:0] rd_nxt;
  logic             rv_nxt;
  logic [REG_W-1:0] rd_r;
  logic             rv_r;
  // Write strobe is taken in only so the port is read; the bank has nothing writable.
  logic             rv_unused;

  assign sample[0] = stop6_interval_value_in;
  assign sample[1] = cal_value_first_in;
  assign sample[2] = cal_value_second_in;
  // Up to 128 samples; the 3-bit avg_log2_in cannot ask for more than 2^7.
  assign target = 8'h01 << avg_log2_in;

  // Sample counter for the averaging cycle.
  always_comb begin
    cnt_nxt = cnt_r;
    if (result_vld_in) begin
      cnt_nxt = (cnt_r + 8'h01 >= target) ? 8'h00 : cnt_r + 8'h01;
    end
  end

  // Accumulators and results; one generate copy per register. Write strobes never touch them.
  for (genvar i = 0; i < 3; i++) begin : g_res
    logic [ACC_W-1:0] sum;
    logic [VAL_W-1:0] avg;
    assign sum = acc_r[i] + ACC_W'(sample[i]);
    assign avg = VAL_W'(sum >> avg_log2_in);
    always_comb begin
      acc_nxt[i] = acc_r[i];
      res_nxt[i] = res_r[i];
      if (result_vld_in) begin
        if (cnt_r + 8'h01 >= target) begin
          acc_nxt[i] = '0;
          res_nxt[i] = {^avg, avg};
        end else begin
          acc_nxt[i] = sum;
        end
      end
    end
  end

  // Read decode; only the selected channel answers, unmapped offsets read zero.
  always_comb begin
    rd_nxt = '0;
    rv_nxt = channel_chip_select_in && rd_en_in;
    if (rv_nxt) begin
      case (addr_in)
        STOP6_OFS: rd_nxt = res_r[0];
        CAL1_OFS:  rd_nxt = res_r[1];
        CAL2_OFS:  rd_nxt = res_r[2];
        default:   rd_nxt = '0;
      endcase
    end
  end

  // All state registers; reset clears every result.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r <= 8'h00;
      rd_r  <= RESULT_RST;
      rv_r  <= 1'b0;
      for (int k = 0; k < 3; k++) begin
        acc_r[k] <= '0;
        res_r[k] <= RESULT_RST;
      end
    end else begin
      cnt_r <= cnt_nxt;
      rd_r  <= rd_nxt;
      rv_r  <= rv_nxt;
      for (int k = 0; k < 3; k++) begin
        acc_r[k] <= acc_nxt[k];
        res_r[k] <= res_nxt[k];
      end
    end
  end

  assign rd_data_out  = rd_r;
  assign rv_unused    = wr_en_in;
  assign rd_valid_out = rv_r;

  // Checks.
  a_par_stop6: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ^res_r[0] == 1'b0) else $error("stop6 parity wrong");
  a_par_cal1: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ^res_r[1] == 1'b0) else $error("cal1 parity wrong");
  a_par_cal2: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ^res_r[2] == 1'b0) else $error("cal2 parity wrong");
  a_write_no_effect: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (wr_en_in && !result_vld_in) |=> $stable(res_r[0]) && $stable(res_r[1]) && $stable(res_r[2]))
    else $error("write changed result");
  a_read_cal2: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (channel_chip_select_in && rd_en_in && addr_in == CAL2_OFS && !result_vld_in)
    |=> rd_valid_out && rd_data_out == res_r[2]) else $error("cal2 read wrong");
  a_read_stop6: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (channel_chip_select_in && rd_en_in && addr_in == STOP6_OFS && !result_vld_in)
    |=> rd_valid_out && rd_data_out == res_r[0]) else $error("stop6 read wrong");
  a_read_unsel: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !channel_chip_select_in |=> !rd_valid_out && rd_data_out == 24'h000000) else $error("unselected answer");
  a_min_interval: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    MIN_INTERVAL_CYC >= 1) else $error("interval count zero");
  a_avg_count: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    cnt_r < 8'(MAX_AVG)) else $error("average count overrun");
  c_read_cal1: cover property (@(posedge ref_clk_in) rd_en_in && channel_chip_select_in && addr_in == CAL1_OFS);
  c_avg_done: cover property (@(posedge ref_clk_in) result_vld_in && cnt_r == 8'h7F);
  c_write_try: cover property (@(posedge ref_clk_in) wr_en_in && channel_chip_select_in);
  c_read_unsel: cover property (@(posedge ref_clk_in) rd_en_in && !channel_chip_select_in);
endmodule : trc_result_regs
`default_nettype wire

// ===== test/trc_host_model.sv
// Host model: drives the register port of one converter channel.
// Assumes its tasks are called at a falling edge of the clock.
`timescale 1ns/10ps
`default_nettype none
module trc_host_model (
  // Clock.
  input  wire logic       ref_clk_in,
  // Register port.
  output logic            channel_chip_select_out,
  output logic            rd_en_out,
  output logic            wr_en_out,
  output logic [7:0]      addr_out
);
  // Port idles deselected so nothing is taken before the first access.
  initial begin
    {channel_chip_select_out, rd_en_out, wr_en_out, addr_out} = '0;
  end
  // One access held across one rising edge; it stays up so back-to-back calls drive each signal once a step.
  task automatic access(input logic cs, input logic wr, input logic [7:0] adr);
    channel_chip_select_out = cs;
    addr_out = adr;
    rd_en_out = ~wr;
    wr_en_out = wr;
    @(negedge ref_clk_in);
  endtask : access
  // Drops the port; called at a falling edge after the last access of a burst.
  task automatic release_port;
    {channel_chip_select_out, rd_en_out, wr_en_out} = '0;
    addr_out = ~addr_out; // A released address must not look valid.
  endtask : release_port
  // Combined mode: a shared start leads both stops, so the flight time is the later interval less the earlier.
  function automatic logic [22:0] flight_time(input logic [22:0] t_begin, input logic [22:0] t_end);
    return t_end - t_begin;
  endfunction : flight_time
endmodule : trc_host_model
`default_nettype wire

// ===== test/trc_result_regs_tb_top.sv
// Bench for the result bank: host model reads, bench feeds samples.
// Assumes each read is answered in the cycle after it is taken.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g,e) begin checks_done++; if ((g)!==(e)) begin failures++; $display("ERROR %0t got %h exp %h",$time,g,e); end end
module trc_result_regs_tb_top;
  import trc_pkg::*;
  logic clk = 0, rst = 1, vld = 0, cs, rd, wr, rv;
  logic [VAL_W-1:0] s6 = 0, c1 = 0, c2 = 0;
  logic [2:0] n = 0;
  logic [7:0] adr;
  logic [REG_W-1:0] rdat;
  int failures = 0, checks_done = 0;
  trc_host_model u_trc_host_model (.ref_clk_in(clk), .channel_chip_select_out(cs), .rd_en_out(rd),
    .wr_en_out(wr), .addr_out(adr));
  trc_result_regs u_trc_result_regs (.ref_clk_in(clk), .sys_rst_in(rst), .result_vld_in(vld),
    .stop6_interval_value_in(s6), .cal_value_first_in(c1), .cal_value_second_in(c2), .avg_log2_in(n),
    .channel_chip_select_in(cs), .rd_en_in(rd), .wr_en_in(wr), .addr_in(adr), .rd_data_out(rdat),
    .rd_valid_out(rv));
  // Clock of 50 MHz.
  initial begin
    forever #10 clk = ~clk;
  end
  // Expected word: even parity on top of the value.
  function automatic logic [REG_W-1:0] w(input logic [VAL_W-1:0] v);
    return {^v, v};
  endfunction : w
  // One read, compared in the only cycle its answer stands.
  task automatic rd_chk(input logic s, input logic [7:0] a, input logic [REG_W-1:0] e, input logic v);
    u_trc_host_model.access(s, 1'b0, a);
    `CHK({rv, rdat}, {v, e})
  endtask : rd_chk
  // Feeds 2^e spaced samples; stepping by 2 makes the mean x+2^e-1.
  task automatic feed(input logic [2:0] e, input logic [VAL_W-1:0] x);
    u_trc_host_model.release_port();
    n = e;
    for (int i = 0; i < (1 << e); i++) begin
      s6 = x + VAL_W'(2 * i);
      c1 = s6 + 23'h4;
      c2 = s6 + 23'h9;
      vld = 1'b1;
      @(negedge clk);
      vld = 1'b0;
      @(negedge clk);
    end
    @(negedge clk);
  endtask : feed
  // Verdict and end of run.
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // Watchdog so a hung run still reaches the verdict.
  initial begin
    #1000000;
    failures++;
    complete_run;
  end
  // Main sequence.
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    for (int a = 'h1A; a <= 'h1C; a++) rd_chk(1'b1, 8'(a), RESULT_RST, 1'b1);
    feed(3'h0, 23'h7FFFF0);
    rd_chk(1'b1, STOP6_OFS, w(23'h7FFFF0), 1'b1);
    rd_chk(1'b1, CAL1_OFS, w(23'h7FFFF4), 1'b1);
    rd_chk(1'b1, CAL2_OFS, w(23'h7FFFF9), 1'b1);
    u_trc_host_model.access(1'b1, 1'b1, STOP6_OFS);
    rd_chk(1'b1, STOP6_OFS, w(23'h7FFFF0), 1'b1);
    rd_chk(1'b0, STOP6_OFS, 24'h000000, 1'b0);
    rd_chk(1'b1, 8'h1D, 24'h000000, 1'b1);
    u_trc_host_model.release_port();
    @(negedge clk);
    `CHK({rv, rdat}, 25'h0000000)
    feed(3'h7, 23'h000010);
    rd_chk(1'b1, STOP6_OFS, w(23'h00008F), 1'b1);
    feed(3'h1, 23'h000020);
    rd_chk(1'b1, CAL2_OFS, w(23'h00002A), 1'b1);
    `CHK(u_trc_host_model.flight_time(23'h000026, 23'h00002A), 23'h000004)
    complete_run;
  end
endmodule : trc_result_regs_tb_top
`default_nettype wire
